// [cfgio_params.svh]
// Register offsets, reset values and pin positions for the configurable I/O port block
`ifndef CFGIO_PARAMS_SVH
`define CFGIO_PARAMS_SVH
`define CFGIO_ADDR_PORT1_LATCH    8'h90
`define CFGIO_ADDR_PORT2_LATCH    8'ha0
`define CFGIO_ADDR_PORT3_LATCH    8'hb0
`define CFGIO_ADDR_PORT4_MODE_LO  8'hbe
`define CFGIO_ADDR_PORT4_MODE_HI  8'hbf
`define CFGIO_ADDR_PORT4_LATCH    8'hc0
`define CFGIO_ADDR_PORT1_MODE_LO  8'hc2
`define CFGIO_ADDR_PORT1_MODE_HI  8'hc3
`define CFGIO_ADDR_PORT2_MODE_LO  8'hc4
`define CFGIO_ADDR_PORT2_MODE_HI  8'hc5
`define CFGIO_ADDR_PORT3_MODE_LO  8'hc6
`define CFGIO_ADDR_PORT3_MODE_HI  8'hc7
`define CFGIO_ADDR_IRQ_WAKE_EN    8'hc8
`define CFGIO_LATCH_RESET         8'hff
`define CFGIO_ANALOG_MASK_PORT2   8'hf0
`define CFGIO_WAKE_MASK_PORT3     8'h4c
`define CFGIO_WAKE_MASK_PORT4     8'h03
`define CFGIO_STRONG_CYCLES    2'd2
`endif

// [cfgio_pkg.sv]
// Types shared by the configurable I/O port block
package cfgio_pkg;
  typedef enum logic [1:0] {
    CFGIO_QUASI    = 2'b00,
    CFGIO_PUSHPULL = 2'b01,
    CFGIO_INPUT    = 2'b10,
    CFGIO_OPENDR   = 2'b11
  } cfgio_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       rmw;
  } cfgio_bus_t;

  typedef struct packed {
    logic [31:0] very_weak_pu;
    logic [31:0] weak_pu;
    logic [31:0] strong_pu;
    logic [31:0] pull_down;
  } cfgio_drive_t;
endpackage

// [cfgio_port.sv]
// Four 8-bit configurable I/O ports with mode, latch, drive and power-down input gating
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "cfgio_params.svh"

module cfgio_port #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 tristate_fuse,
  input  wire logic                 power_down,
  input  wire logic                 ext_reset_en,
  input  wire logic                 osc_pins_used,
  input  wire cfgio_pkg::cfgio_bus_t bus,
  output logic [7:0]                rdata,
  input  wire logic [31:0]          pin_in,
  output logic [31:0]               pin_out,
  output logic [31:0]               pin_oe,
  output logic [31:0]               pin_sensed,
  output cfgio_pkg::cfgio_drive_t   drive,
  output logic [31:0]               pin_usable
);
  import cfgio_pkg::*;

  logic [7:0]  latch    [NUM_PORTS];
  logic [7:0]  mode_lo  [NUM_PORTS];
  logic [7:0]  mode_hi  [NUM_PORTS];
  logic [7:0]  irq_wake_en;
  logic [7:0]  latch_q  [NUM_PORTS];
  logic [1:0]  strong_cnt [32];
  logic [31:0] in_gate;
  logic        fuse_seen;

  function automatic cfgio_mode_t pin_mode(input logic lo, input logic hi);
    pin_mode = cfgio_mode_t'({lo, hi});
  endfunction

  // Index of a latch or mode register, or -1 when unmapped
  function automatic int reg_port(input logic [7:0] a, input int kind);
    reg_port = -1;
    case (kind)
      0: case (a)
        `CFGIO_ADDR_PORT1_LATCH: reg_port = 0;
        `CFGIO_ADDR_PORT2_LATCH: reg_port = 1;
        `CFGIO_ADDR_PORT3_LATCH: reg_port = 2;
        `CFGIO_ADDR_PORT4_LATCH: reg_port = 3;
        default:                 reg_port = -1;
      endcase
      1: case (a)
        `CFGIO_ADDR_PORT1_MODE_LO: reg_port = 0;
        `CFGIO_ADDR_PORT2_MODE_LO: reg_port = 1;
        `CFGIO_ADDR_PORT3_MODE_LO: reg_port = 2;
        `CFGIO_ADDR_PORT4_MODE_LO: reg_port = 3;
        default:                   reg_port = -1;
      endcase
      default: case (a)
        `CFGIO_ADDR_PORT1_MODE_HI: reg_port = 0;
        `CFGIO_ADDR_PORT2_MODE_HI: reg_port = 1;
        `CFGIO_ADDR_PORT3_MODE_HI: reg_port = 2;
        `CFGIO_ADDR_PORT4_MODE_HI: reg_port = 3;
        default:                   reg_port = -1;
      endcase
    endcase
  endfunction

  // Fuse is sampled on the first clock after reset release; registers stay
  // at their input-only reset value until then, which is the safe state.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      fuse_seen <= 1'b0;
    else
      fuse_seen <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        latch[p]   <= `CFGIO_LATCH_RESET;
        mode_lo[p] <= 8'hff;
        mode_hi[p] <= 8'h00;
      end
      irq_wake_en <= 8'h00;
    end
    else if (!fuse_seen)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        mode_lo[p] <= tristate_fuse ? 8'hff : 8'h00;
        mode_hi[p] <= 8'h00;
      end
      mode_lo[1] <= tristate_fuse ? 8'hff : `CFGIO_ANALOG_MASK_PORT2;
    end
    else if (bus.wr)
    begin
      if (reg_port(bus.addr, 0) >= 0)
        latch[reg_port(bus.addr, 0)] <= bus.wdata;
      if (reg_port(bus.addr, 1) >= 0)
        mode_lo[reg_port(bus.addr, 1)] <= bus.wdata;
      if (reg_port(bus.addr, 2) >= 0)
        mode_hi[reg_port(bus.addr, 2)] <= bus.wdata;
      if (bus.addr == `CFGIO_ADDR_IRQ_WAKE_EN)
        irq_wake_en <= bus.wdata;
    end
  end

  // Previous latch value, used to catch 0->1 edges
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      for (int p = 0; p < NUM_PORTS; p++)
        latch_q[p] <= `CFGIO_LATCH_RESET;
    else
      for (int p = 0; p < NUM_PORTS; p++)
        latch_q[p] <= latch[p];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      for (int i = 0; i < 32; i++)
        strong_cnt[i] <= 2'd0;
    else
      for (int i = 0; i < 32; i++)
        if (pin_mode(mode_lo[i/8][i%8], mode_hi[i/8][i%8]) == CFGIO_QUASI
            && latch[i/8][i%8] && !latch_q[i/8][i%8])
          // Rise cycle itself is the first strong cycle, so count one less
          strong_cnt[i] <= `CFGIO_STRONG_CYCLES - 2'd1;
        else if (strong_cnt[i] != 2'd0)
          strong_cnt[i] <= strong_cnt[i] - 2'd1;
  end

  // Input gating in power-down; wake pins and enabled port 1 interrupt pins stay live
  always_comb
  begin
    in_gate = 32'hffffffff;
    if (power_down)
      in_gate = {`CFGIO_WAKE_MASK_PORT4, `CFGIO_WAKE_MASK_PORT3, 8'h00, irq_wake_en};
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pin_sensed <= 32'h0;
    else
      pin_sensed <= pin_in & in_gate;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      drive <= '0;
    else
      for (int i = 0; i < 32; i++)
      begin
        logic l;
        l = latch[i/8][i%8];
        drive.very_weak_pu[i] <= 1'b0;
        drive.weak_pu[i]      <= 1'b0;
        drive.strong_pu[i]    <= 1'b0;
        drive.pull_down[i]    <= 1'b0;
        case (pin_mode(mode_lo[i/8][i%8], mode_hi[i/8][i%8]))
          CFGIO_QUASI:
          begin
            drive.very_weak_pu[i] <= l;
            drive.weak_pu[i]      <= l & pin_in[i];
            drive.strong_pu[i]    <= l & (strong_cnt[i] != 2'd0 || !latch_q[i/8][i%8]);
            drive.pull_down[i]    <= !l;
          end
          CFGIO_PUSHPULL:
          begin
            drive.strong_pu[i] <= l;
            drive.pull_down[i] <= !l;
          end
          CFGIO_OPENDR:
            drive.pull_down[i] <= !l;
          CFGIO_INPUT:
            drive.pull_down[i] <= 1'b0;
          default:
            drive.pull_down[i] <= 1'b0;
        endcase
      end
  end

  // Digital view of the pad: driven low by pull-down, high by any pull-up
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      pin_oe[i]  = drive.pull_down[i] | drive.strong_pu[i] | drive.weak_pu[i] | drive.very_weak_pu[i];
      pin_out[i] = !drive.pull_down[i];
    end
  end

  // Reset and oscillator pins are lost to I/O when claimed by their functions
  always_comb
  begin
    pin_usable = 32'hffffffff;
    if (ext_reset_en)
      pin_usable[22] = 1'b0;
    if (osc_pins_used)
      pin_usable[25:24] = 2'b00;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      rdata <= 8'h00;
      if (reg_port(bus.addr, 0) >= 0)
        rdata <= bus.rmw ? latch[reg_port(bus.addr, 0)]
                         : pin_sensed[8*reg_port(bus.addr, 0) +: 8];
      if (reg_port(bus.addr, 1) >= 0)
        rdata <= mode_lo[reg_port(bus.addr, 1)];
      if (reg_port(bus.addr, 2) >= 0)
        rdata <= mode_hi[reg_port(bus.addr, 2)];
      if (bus.addr == `CFGIO_ADDR_IRQ_WAKE_EN)
        rdata <= irq_wake_en;
    end
  end
endmodule // cfgio_port

// [cfgio_port_assertions.sv]
// Concurrent checks on the configurable I/O port ports
`timescale 1ns/1ps
module cfgio_chk import cfgio_pkg::*; #(parameter int NUM_PORTS = 4) (
  input wire logic         clk_sys,
  input wire logic         resetn,
  input wire logic         power_down,
  input wire logic         ext_reset_en,
  input wire logic         osc_pins_used,
  input wire cfgio_bus_t   bus,
  input wire logic [7:0]   rdata,
  input wire logic [31:0]  pin_in,
  input wire logic [31:0]  pin_out,
  input wire logic [31:0]  pin_oe,
  input wire logic [31:0]  pin_sensed,
  input wire cfgio_drive_t drive,
  input wire logic [31:0]  pin_usable
);
  localparam logic [31:0] WAKE = 32'h034c0000;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Very weak pull-up marks quasi mode, so push-pull drive is excluded
  property p_strong; ($rose(drive.strong_pu[0]) && drive.very_weak_pu[0]) |=> drive.strong_pu[0] ##1 !drive.strong_pu[0]; endproperty
  a_strong: assert property (p_strong) else $error("strong pull-up length wrong");
  property p_pd_out; (drive.pull_down & (pin_out | ~pin_oe)) == 32'h0; endproperty
  a_pd_out: assert property (p_pd_out) else $error("pull-down not driving low");
  property p_pd_pu; (drive.pull_down & (drive.strong_pu | drive.weak_pu | drive.very_weak_pu)) == 32'h0; endproperty
  a_pd_pu: assert property (p_pd_pu) else $error("pull-up beside pull-down");
  property p_weak; (drive.weak_pu & ~drive.very_weak_pu) == 32'h0; endproperty
  a_weak: assert property (p_weak) else $error("weak pull-up without latch one");
  property p_wake; $past(power_down) |-> (pin_sensed & WAKE) == ($past(pin_in) & WAKE); endproperty
  a_wake: assert property (p_wake) else $error("wake pin input gated");
  property p_unmap; (bus.rd && bus.addr == 8'h00) |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !$past(bus.rd) |-> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst; pin_usable[22] == !ext_reset_en; endproperty
  a_rst: assert property (p_rst) else $error("reset pin usability wrong");
  property p_osc; pin_usable[25:24] == {2{!osc_pins_used}}; endproperty
  a_osc: assert property (p_osc) else $error("oscillator pin usability wrong");
  c_strong: cover property ($rose(drive.strong_pu[0]));
  c_pd: cover property (power_down && pin_sensed[18]);
  c_rmw: cover property (bus.rd && bus.rmw);
endmodule // cfgio_chk
bind cfgio_port cfgio_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk_sys, .resetn, .power_down, .ext_reset_en,
  .osc_pins_used, .bus, .rdata, .pin_in, .pin_out, .pin_oe, .pin_sensed, .drive, .pin_usable);

// [test_configurable_io_port_pins.sv]
// Register-level bench for the configurable I/O port block
`timescale 1ns/1ps
module test_configurable_io_port_pins;
  import cfgio_pkg::*;
  logic         clk_sys = 0, resetn = 0, tristate_fuse = 0, power_down = 0;
  logic         ext_reset_en = 0, osc_pins_used = 0;
  cfgio_bus_t   bus = '0;
  logic [31:0]  pin_in = 32'hffffffff;
  logic [7:0]   rdata;
  logic [31:0]  pin_out, pin_oe, pin_sensed, pin_usable;
  cfgio_drive_t drive;
  logic [7:0]   mlo [4] = '{8'hc2, 8'hc4, 8'hc6, 8'hbe};
  int           fails = 0, checks_done = 0;
  cfgio_port dut (.clk_sys, .resetn, .tristate_fuse, .power_down, .ext_reset_en, .osc_pins_used,
    .bus, .rdata, .pin_in, .pin_out, .pin_oe, .pin_sensed, .drive, .pin_usable);
  initial forever #5 clk_sys = ~clk_sys;
  task give_verdict;
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0, rmw: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  // Data appear in the cycle after the strobe and hold until the next read
  task rd(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, rmw: m};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task rst(input logic f);
    @(posedge clk_sys);
    resetn <= 1'b0;
    tristate_fuse <= f;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
  initial
  begin
    rst(1'b1);
    for (int p = 0; p < 4; p++)
    begin
      rd(mlo[p], 1'b0, 8'hff);
      rd(mlo[p] + 8'h01, 1'b0, 8'h00);
    end
    @(posedge clk_sys);
    pin_in <= 32'h12345678;
    settle;
    chk(drive.very_weak_pu | drive.weak_pu | drive.strong_pu | drive.pull_down, 32'h0);
    chk(pin_oe, 32'h0);
    rd(8'h90, 1'b0, 8'h78);
    rd(8'hb0, 1'b0, 8'h34);
    rd(8'h90, 1'b1, 8'hff);
    @(posedge clk_sys);
    pin_in <= 32'hffffffff;
    rst(1'b0);
    rd(8'hc2, 1'b0, 8'h00);
    rd(8'hc4, 1'b0, 8'hf0);
    rd(8'hc5, 1'b0, 8'h00);
    rd(8'h90, 1'b1, 8'hff);
    chk(drive.very_weak_pu, 32'hffff0fff);
    chk(drive.weak_pu, 32'hffff0fff);
    pin_in <= 32'hfffffffe;
    settle;
    chk(drive.weak_pu, 32'hffff0ffe);
    chk(drive.very_weak_pu, 32'hffff0fff);
    wr(8'h90, 8'h00);
    settle;
    chk(drive.pull_down, 32'h000000ff);
    wr(8'h90, 8'hff);
    repeat (2)
    begin
      @(posedge clk_sys);
      #1 chk(drive.strong_pu[7:0], 8'hff);
    end
    settle;
    chk(drive.strong_pu, 32'h0);
    wr(8'hc3, 8'hff);
    settle;
    chk({drive.strong_pu[7:0], pin_oe[7:0], pin_out[7:0]}, 32'hffffff);
    wr(8'h90, 8'h00);
    settle;
    chk({drive.strong_pu[7:0], drive.pull_down[7:0]}, 32'h00ff);
    wr(8'hc2, 8'hff);
    wr(8'h90, 8'h0f);
    settle;
    chk({drive.strong_pu[7:0], drive.weak_pu[7:0], drive.very_weak_pu[7:0], drive.pull_down[7:0]}, 32'hf0);
    rd(8'hc3, 1'b0, 8'hff);
    rd(8'h90, 1'b1, 8'h0f);
    wr(8'h01, 8'h55);
    rd(8'h01, 1'b0, 8'h00);
    wr(8'hc8, 8'h01);
    power_down <= 1'b1;
    pin_in <= 32'h0;
    settle;
    chk(pin_sensed & 32'h034c0001, 32'h0);
    @(posedge clk_sys);
    pin_in <= 32'hffffffff;
    settle;
    chk(pin_sensed, 32'h034c0001);
    @(posedge clk_sys);
    ext_reset_en <= 1'b1;
    osc_pins_used <= 1'b1;
    settle;
    chk({pin_usable[25:24], pin_usable[22]}, 32'h0);
    give_verdict;
  end
  initial
  begin
    #20000;
    fails++;
    give_verdict;
  end
endmodule // test_configurable_io_port_pins
